// ===== verilog/dcf_pkg.sv
package dcf_pkg;
   // ==========================================================
   // configuration space addresses
   localparam logic [23:0] DCF_ADDR_BOOT  = 24'hf80000;
   localparam logic [23:0] DCF_ADDR_RSVD  = 24'hf80002;
   localparam logic [23:0] DCF_ADDR_GEN   = 24'hf80004;
   localparam logic [23:0] DCF_ADDR_OSEL  = 24'hf80006;
   localparam logic [23:0] DCF_ADDR_OOPT  = 24'hf80008;
   localparam logic [23:0] DCF_ADDR_WDT   = 24'hf8000a;
   localparam logic [23:0] DCF_ADDR_POR   = 24'hf8000c;
   localparam logic [23:0] DCF_ADDR_DBG   = 24'hf8000e;
   localparam logic [23:0] DCF_ADDR_CMP   = 24'hf80010;
   localparam int          DCF_NWORDS     = 9;
   // ==========================================================
   // implemented-bit masks; unimplemented bits read as zero
   localparam logic [7:0] DCF_MASK_BOOT = 8'h0f;
   localparam logic [7:0] DCF_MASK_GEN  = 8'h07;
   localparam logic [7:0] DCF_MASK_OSEL = 8'h87;
   localparam logic [7:0] DCF_MASK_OOPT = 8'hc7;
   localparam logic [7:0] DCF_MASK_WDT  = 8'hdf;
   localparam logic [7:0] DCF_MASK_POR  = 8'h67;
   localparam logic [7:0] DCF_MASK_DBG  = 8'he3;
   localparam logic [7:0] DCF_MASK_CMP  = 8'h3f;
   // ==========================================================
   // field positions
   localparam int DCF_BOOT_WRITE_PROTECT_BIT    = 0;
   localparam int DCF_BSS_LSB     = 1;
   localparam int DCF_GENERAL_WRITE_PROTECT_BIT    = 0;
   localparam int DCF_GSS_LSB     = 1;
   localparam int DCF_TWO_SPEED_STARTUP_BIT    = 7;
   localparam int DCF_NOSC_LSB    = 0;
   localparam int DCF_CKSM_LSB    = 6;
   localparam int DCF_OSCIO_BIT   = 2;
   localparam int DCF_PMD_LSB     = 0;
   localparam int DCF_WDEN_BIT    = 7;
   localparam int DCF_WIN_BIT     = 6;
   localparam int DCF_PRE_BIT     = 4;
   localparam int DCF_POST_LSB    = 0;
   localparam int DCF_QIO_BIT     = 6;
   localparam int DCF_SS_BIT      = 5;
   localparam int DCF_POWER_UP_DELAY_LSB    = 0;
   localparam int DCF_JTAG_BIT    = 5;
   localparam int DCF_ICS_LSB     = 0;
   localparam int DCF_POL1_BIT    = 5;
   localparam int DCF_HY1_LSB     = 3;
   localparam int DCF_POL0_BIT    = 2;
   localparam int DCF_HY0_LSB     = 0;
   // ==========================================================
   // boot segment end addresses
   localparam logic [23:0] DCF_BOOT_END_S = 24'h0003fe;
   localparam logic [23:0] DCF_BOOT_END_M = 24'h0007fe;
   localparam logic [23:0] DCF_BOOT_END_L = 24'h000ffe;
   // security levels
   localparam logic [1:0] DCF_SEC_NONE = 2'h0;
   localparam logic [1:0] DCF_SEC_STD  = 2'h1;
   localparam logic [1:0] DCF_SEC_HIGH = 2'h2;
   // oscillator source codes
   localparam logic [2:0] DCF_NOSC_FRC    = 3'h0;
   localparam logic [2:0] DCF_NOSC_FRCPLL = 3'h1;
   localparam logic [2:0] DCF_NOSC_PRI    = 3'h2;
   localparam logic [2:0] DCF_NOSC_PRIPLL = 3'h3;
   localparam logic [2:0] DCF_NOSC_SEC    = 3'h4;
   localparam logic [2:0] DCF_NOSC_LPRC   = 3'h5;
   localparam logic [2:0] DCF_NOSC_FRC16  = 3'h6;
   localparam logic [2:0] DCF_NOSC_FRCDIV = 3'h7;
   // primary oscillator modes
   localparam logic [1:0] DCF_PMD_EC  = 2'h0;
   localparam logic [1:0] DCF_PMD_XT  = 2'h1;
   localparam logic [1:0] DCF_PMD_HS  = 2'h2;
   localparam logic [1:0] DCF_PMD_OFF = 2'h3;
   // prescaler ratios
   localparam logic [7:0] DCF_PRE_128 = 8'h80;
   localparam logic [7:0] DCF_PRE_32  = 8'h20;
   // ==========================================================
   // timing
   localparam int DCF_CLK_MHZ      = 100;
   localparam int DCF_SETTLE_US    = 20;
   localparam int DCF_SETTLE_CYC   = DCF_SETTLE_US * DCF_CLK_MHZ;
   localparam int DCF_POWER_UP_DELAY_MIN_MS  = 2;
   localparam int DCF_FSCM_US      = 100;
   localparam int DCF_FSCM_CYC     = DCF_FSCM_US * DCF_CLK_MHZ;
   localparam int DCF_CNT_W        = 24;
endpackage : dcf_pkg

// ===== verilog/dcf_config_loader.sv
`timescale 1ns/1ps
module dcf_config_loader
   import dcf_pkg::*;
#(
   parameter int POWER_UP_DELAY_MIN_CYC = DCF_POWER_UP_DELAY_MIN_MS * 1000 * DCF_CLK_MHZ, // 2 ms unit
   parameter int FSCM_CYC     = DCF_FSCM_CYC,                         // fail-safe delay
   parameter int SETTLE_CYC   = DCF_SETTLE_CYC                        // regulator settle
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // nonvolatile words, raw, one per configuration address except DCF_ADDR_RSVD
   input  wire logic [7:0]  nv_boot,
   input  wire logic [7:0]  nv_gen,
   input  wire logic [7:0]  nv_osel,
   input  wire logic [7:0]  nv_oopt,
   input  wire logic [7:0]  nv_wdt,
   input  wire logic [7:0]  nv_por,
   input  wire logic [7:0]  nv_dbg,
   input  wire logic [7:0]  nv_cmp,
   // supply, clock status and control events
   input  wire logic        brown_out,
   input  wire logic        power_resume,
   input  wire logic        osc_start_done,
   input  wire logic        pll_lock,
   input  wire logic        watchdog_soft_enable,
   input  wire logic        brown_out_flag_clr,
   // table read port
   input  wire logic        tbl_rd,
   input  wire logic [23:0] tbl_addr,
   output logic      [7:0]  tbl_rdata,
   // write qualification
   input  wire logic [23:0] flash_wr_addr,
   input  wire logic        flash_wr_req,
   output logic             flash_wr_allow,
   // decoded controls
   output logic      [23:0] boot_segment_end,
   output logic             boot_segment_present,
   output logic      [1:0]  boot_security,
   output logic      [1:0]  general_security,
   output logic             general_write_protect,
   output logic      [2:0]  initial_oscillator_select,
   output logic      [2:0]  active_clock_source,
   output logic             clock_switch_enable,
   output logic             failsafe_monitor_enable,
   output logic             osc_pin_clock_out,
   output logic      [1:0]  primary_osc_mode,
   output logic             watchdog_run,
   output logic             watchdog_window_mode,
   output logic      [7:0]  watchdog_prescale_ratio,
   output logic      [15:0] watchdog_postscale_ratio,
   output logic             jtag_enable,
   output logic      [2:0]  debug_pair_onehot,
   output logic             encoder_primary_pins,
   output logic             slave_select_alternate,
   output logic             even_hysteresis_polarity,
   output logic      [1:0]  even_hysteresis_amount,
   output logic             odd_hysteresis_polarity,
   output logic      [1:0]  odd_hysteresis_amount,
   output logic             clock_hold,
   output logic             core_reset,
   output logic             exec_enable,
   output logic             brown_out_flag
);
   initial
   begin
      if (POWER_UP_DELAY_MIN_CYC < 1 || FSCM_CYC < 1 || SETTLE_CYC < 8)
         $error("delay counts too small for this sequencer");
   end

   // ==========================================================
   // sequencer states
   typedef enum logic [3:0] {
      ST_SETTLE = 4'b0001,  // regulator settling
      ST_HOLD   = 4'b0010,  // clock and power-up delays
      ST_RUN    = 4'b0100,  // executing
      ST_LATCH  = 4'b1000   // capture fuses
   } dcf_state_t;

   typedef struct packed {
      dcf_state_t         st;
      logic [7:0]         boot, gen, osel, oopt, wdt, por, dbg, cmp;
      logic [DCF_CNT_W-1:0] settle_cnt;   // regulator settle counter
      logic [31:0]        power_up_delay_cnt;       // power-up delay counter
      logic               two_speed_done; // switched off fast RC
      logic               bor_flag;       // sticky brown-out status
      logic [7:0]         rdata;          // table read data
   } dcf_state_s_t;

   dcf_state_s_t s_q, s_d;

   // ==========================================================
   // fuse decode helpers
   function automatic logic [1:0] gss_level(input logic [1:0] f);
      gss_level = (f == 2'b11) ? DCF_SEC_NONE :
                  (f == 2'b10) ? DCF_SEC_STD  : DCF_SEC_HIGH;
   endfunction : gss_level

   function automatic logic uses_pll(input logic [2:0] n);
      uses_pll = (n == DCF_NOSC_PRIPLL) || (n == DCF_NOSC_FRCPLL);
   endfunction : uses_pll

   function automatic logic uses_pri(input logic [2:0] n);
      uses_pri = (n == DCF_NOSC_PRI) || (n == DCF_NOSC_PRIPLL);
   endfunction : uses_pri

   // power-up delay in cycles: code 1 is base, doubles per step
   function automatic logic [31:0] power_up_delay_cycles(input logic [2:0] c);
      power_up_delay_cycles = (c == 3'h0) ? 32'h0 :
                    32'(POWER_UP_DELAY_MIN_CYC) << (c - 3'h1);
   endfunction : power_up_delay_cycles

   // ==========================================================
   // field views of the latched words
   logic [2:0] bss, nosc;
   logic [1:0] pmd;
   logic       crystal, pll, pri;
   logic        hold_clk, power_up_delay_done;  // clock hold and power-up delay terms
   logic [31:0] power_up_delay_target;          // power-up delay target in cycles
   assign bss     = s_q.boot[DCF_BSS_LSB +: 3];
   assign nosc    = s_q.osel[DCF_NOSC_LSB +: 3];
   assign pmd     = s_q.oopt[DCF_PMD_LSB +: 2];
   assign pri     = uses_pri(nosc);
   assign pll     = uses_pll(nosc);
   assign crystal = pri && (pmd == DCF_PMD_XT || pmd == DCF_PMD_HS);

   // ==========================================================
   // next-state logic
   always_comb
   begin
      s_d = s_q;
      // reset latch: capture all words in the first cycle after reset is released
      if (s_q.st == ST_LATCH)
      begin
         s_d.boot = nv_boot & DCF_MASK_BOOT;
         s_d.gen  = nv_gen  & DCF_MASK_GEN;
         s_d.osel = nv_osel & DCF_MASK_OSEL;
         s_d.oopt = nv_oopt & DCF_MASK_OOPT;
         s_d.wdt  = nv_wdt  & DCF_MASK_WDT;
         s_d.por  = nv_por  & DCF_MASK_POR;
         s_d.dbg  = nv_dbg  & DCF_MASK_DBG;
         s_d.cmp  = nv_cmp  & DCF_MASK_CMP;
         s_d.st   = ST_SETTLE;
         s_d.settle_cnt = '0;
      end
      unique case (s_q.st)
         ST_LATCH: ;
         ST_SETTLE:
         begin
            if (s_q.settle_cnt >= DCF_CNT_W'(SETTLE_CYC - 1))
            begin
               s_d.st = ST_HOLD;
               s_d.power_up_delay_cnt = '0;
            end
            else
               s_d.settle_cnt = s_q.settle_cnt + 1'b1;
         end
         ST_HOLD:
         begin
            if (!hold_clk && power_up_delay_done)
               s_d.st = ST_RUN;
            if (!power_up_delay_done)
               s_d.power_up_delay_cnt = s_q.power_up_delay_cnt + 32'h1;
         end
         ST_RUN: ;
      endcase
      // two-speed start hands over once selected source is ready
      if (s_q.st != ST_LATCH && !hold_clk)
         s_d.two_speed_done = 1'b1;
      // table read, only configuration space answers
      s_d.rdata = 8'h00;
      if (tbl_rd)
      begin
         unique case (tbl_addr)
            DCF_ADDR_BOOT: s_d.rdata = s_q.boot;
            DCF_ADDR_GEN:  s_d.rdata = s_q.gen;
            DCF_ADDR_OSEL: s_d.rdata = s_q.osel;
            DCF_ADDR_OOPT: s_d.rdata = s_q.oopt;
            DCF_ADDR_WDT:  s_d.rdata = s_q.wdt;
            DCF_ADDR_POR:  s_d.rdata = s_q.por;
            DCF_ADDR_DBG:  s_d.rdata = s_q.dbg;
            DCF_ADDR_CMP:  s_d.rdata = s_q.cmp;
            default:       s_d.rdata = 8'h00;
         endcase
      end
      // sticky brown-out flag, set wins over clear
      if (brown_out_flag_clr)
         s_d.bor_flag = 1'b0;
      if (brown_out)
         s_d.bor_flag = 1'b1;
      // brown-out or resume restarts the sequence
      if (brown_out || power_resume)
      begin
         s_d.st = ST_SETTLE;
         s_d.settle_cnt = '0;
         s_d.two_speed_done = 1'b0;
      end
   end

   // hold and delay terms
   always_comb
   begin
      // oscillator start-up, then pll lock where used
      hold_clk = (pri && pmd != DCF_PMD_EC && !osc_start_done) || (pll && !pll_lock);
      power_up_delay_target = power_up_delay_cycles(s_q.por[DCF_POWER_UP_DELAY_LSB +: 3]);
      if (power_up_delay_target == 32'h0 && crystal)
         power_up_delay_target = 32'(FSCM_CYC);
      power_up_delay_done = (s_q.power_up_delay_cnt >= power_up_delay_target);
   end

   // ==========================================================
   // state register, synchronous reset
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
         s_q.st <= ST_LATCH;
         s_q.boot <= 8'hff;   // unprogrammed reads 1
         s_q.rdata <= 8'h00;
      end
      else
         s_q <= s_d;
   end

   // ==========================================================
   // decoded outputs
   always_comb
   begin
      boot_segment_present = (bss[1:0] != 2'b11);
      boot_security = !boot_segment_present ? DCF_SEC_NONE :
                      (bss[2] ? DCF_SEC_STD : DCF_SEC_HIGH);
      unique case (bss[1:0])
         2'b10:   boot_segment_end = DCF_BOOT_END_S;
         2'b01:   boot_segment_end = DCF_BOOT_END_M;
         2'b00:   boot_segment_end = DCF_BOOT_END_L;
         default: boot_segment_end = 24'h000000;
      endcase
      general_security      = gss_level(s_q.gen[DCF_GSS_LSB +: 2]);
      general_write_protect = !s_q.gen[DCF_GENERAL_WRITE_PROTECT_BIT];
      // write gate: boot region by its bit, rest by general bit
      if (boot_segment_present && flash_wr_addr <= boot_segment_end)
         flash_wr_allow = flash_wr_req && s_q.boot[DCF_BOOT_WRITE_PROTECT_BIT];
      else
         flash_wr_allow = flash_wr_req && s_q.gen[DCF_GENERAL_WRITE_PROTECT_BIT];
      initial_oscillator_select = nosc;
      active_clock_source = (s_q.osel[DCF_TWO_SPEED_STARTUP_BIT] && !s_q.two_speed_done)
                            ? DCF_NOSC_FRC : nosc;
      clock_switch_enable     = !s_q.oopt[DCF_CKSM_LSB + 1];
      failsafe_monitor_enable = (s_q.oopt[DCF_CKSM_LSB +: 2] == 2'b00);
      // crystal modes own the pin whatever source is selected
      osc_pin_clock_out = s_q.oopt[DCF_OSCIO_BIT] &&
                          !(pmd == DCF_PMD_XT || pmd == DCF_PMD_HS);
      primary_osc_mode  = pmd;
      watchdog_run = s_q.wdt[DCF_WDEN_BIT] || watchdog_soft_enable;
      watchdog_window_mode    = !s_q.wdt[DCF_WIN_BIT];
      watchdog_prescale_ratio = s_q.wdt[DCF_PRE_BIT] ? DCF_PRE_128 : DCF_PRE_32;
      watchdog_postscale_ratio = 16'h1 << s_q.wdt[DCF_POST_LSB +: 4];
      jtag_enable = s_q.dbg[DCF_JTAG_BIT];
      unique case (s_q.dbg[DCF_ICS_LSB +: 2])
         2'b11:   debug_pair_onehot = 3'b001;
         2'b10:   debug_pair_onehot = 3'b010;
         2'b01:   debug_pair_onehot = 3'b100;
         default: debug_pair_onehot = 3'b000;
      endcase
      encoder_primary_pins   = s_q.por[DCF_QIO_BIT];
      slave_select_alternate = s_q.por[DCF_SS_BIT];
      even_hysteresis_polarity = s_q.cmp[DCF_POL0_BIT];
      even_hysteresis_amount   = s_q.cmp[DCF_HY0_LSB +: 2];
      odd_hysteresis_polarity  = s_q.cmp[DCF_POL1_BIT];
      odd_hysteresis_amount    = s_q.cmp[DCF_HY1_LSB +: 2];
      clock_hold  = (s_q.st != ST_RUN) && hold_clk;
      core_reset  = (s_q.st != ST_RUN);
      exec_enable = (s_q.st == ST_RUN);
      brown_out_flag = s_q.bor_flag;
   end
   assign tbl_rdata = s_q.rdata;

   // ==========================================================
   // checks
   a_bor_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
      brown_out |=> brown_out_flag) else $error("brown-out flag not set");
   a_bor_resets: assert property (@(posedge sys_clk) disable iff (!rst_n)
      brown_out |=> core_reset) else $error("brown-out gave no reset");
   a_settle_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      power_resume |=> !exec_enable [*8]) else $error("ran during settle");
   a_boot_wr_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (boot_segment_present && flash_wr_addr <= boot_segment_end && !s_q.boot[0])
      |-> !flash_wr_allow) else $error("boot write not blocked");
   a_wdt_forced: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_q.wdt[DCF_WDEN_BIT] |-> watchdog_run) else $error("watchdog not forced");
   a_pll_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pll && !pll_lock && s_q.st == ST_HOLD) |=> !exec_enable)
      else $error("ran without lock");
   a_fuse_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == ST_RUN) |=> $stable(s_q.wdt)) else $error("fuses changed");
   a_cksm_mon: assert property (@(posedge sys_clk) disable iff (!rst_n)
      failsafe_monitor_enable |-> clock_switch_enable) else $error("monitor alone");
endmodule : dcf_config_loader

// ===== verification/dcf_config_loader_tb.sv
`timescale 1ns/1ps
module dcf_config_loader_tb;
   import dcf_pkg::*;
   // ==========================================================
   // shortened counts so the run stays brief
   localparam int POWER_UP_DELAY_C = 4;
   localparam int FSCM_C = 3;
   localparam int SETL_C = 8;
   localparam logic [23:0] ADR [8] = '{DCF_ADDR_BOOT, DCF_ADDR_GEN, DCF_ADDR_OSEL,
      DCF_ADDR_OOPT, DCF_ADDR_WDT, DCF_ADDR_POR, DCF_ADDR_DBG, DCF_ADDR_CMP};
   localparam logic [7:0]  MSK [8] = '{DCF_MASK_BOOT, DCF_MASK_GEN, DCF_MASK_OSEL,
      DCF_MASK_OOPT, DCF_MASK_WDT, DCF_MASK_POR, DCF_MASK_DBG, DCF_MASK_CMP};
   logic        sys_clk, rst_n, brown_out, power_resume, osc_start_done, pll_lock;
   logic        watchdog_soft_enable, brown_out_flag_clr, tbl_rd, flash_wr_req;
   logic [7:0]  nv_boot, nv_gen, nv_osel, nv_oopt, nv_wdt, nv_por, nv_dbg, nv_cmp;
   logic [23:0] tbl_addr, flash_wr_addr, boot_segment_end;
   logic [7:0]  tbl_rdata, watchdog_prescale_ratio;
   logic [15:0] watchdog_postscale_ratio;
   logic [2:0]  initial_oscillator_select, active_clock_source, debug_pair_onehot;
   logic [1:0]  boot_security, general_security, primary_osc_mode;
   logic [1:0]  even_hysteresis_amount, odd_hysteresis_amount;
   logic        flash_wr_allow, boot_segment_present, general_write_protect;
   logic        clock_switch_enable, failsafe_monitor_enable, osc_pin_clock_out;
   logic        watchdog_run, watchdog_window_mode, jtag_enable, encoder_primary_pins;
   logic        slave_select_alternate, even_hysteresis_polarity, odd_hysteresis_polarity;
   logic        clock_hold, core_reset, exec_enable, brown_out_flag;
   logic [7:0]  w [8];   // fuse words the model believes latched
   logic [7:0]  sv [8];  // saved copy across a scramble
   int          num_errors, num_checks, n;

   dcf_config_loader #(.POWER_UP_DELAY_MIN_CYC(POWER_UP_DELAY_C), .FSCM_CYC(FSCM_C), .SETTLE_CYC(SETL_C)) i_dut (
      .sys_clk, .rst_n, .nv_boot, .nv_gen, .nv_osel, .nv_oopt, .nv_wdt, .nv_por,
      .nv_dbg, .nv_cmp, .brown_out, .power_resume, .osc_start_done, .pll_lock,
      .watchdog_soft_enable, .brown_out_flag_clr, .tbl_rd, .tbl_addr, .tbl_rdata,
      .flash_wr_addr, .flash_wr_req, .flash_wr_allow, .boot_segment_end,
      .boot_segment_present, .boot_security, .general_security, .general_write_protect,
      .initial_oscillator_select, .active_clock_source, .clock_switch_enable,
      .failsafe_monitor_enable, .osc_pin_clock_out, .primary_osc_mode, .watchdog_run,
      .watchdog_window_mode, .watchdog_prescale_ratio, .watchdog_postscale_ratio,
      .jtag_enable, .debug_pair_onehot, .encoder_primary_pins, .slave_select_alternate,
      .even_hysteresis_polarity, .even_hysteresis_amount, .odd_hysteresis_polarity,
      .odd_hysteresis_amount, .clock_hold, .core_reset, .exec_enable, .brown_out_flag);

   // ==========================================================
   // clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   // ==========================================================
   // compare and bus helpers
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk

   // table read: taken at one edge, data stands the cycle after
   task automatic rd(input logic [23:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      tbl_rd   <= 1'b1;
      tbl_addr <= a;
      @(posedge sys_clk);
      tbl_rd <= 1'b0;
      @(negedge sys_clk);
      chk("tbl_rdata", {16'h0, e}, {16'h0, tbl_rdata});
   endtask : rd

   task automatic drive();
      @(posedge sys_clk);
      nv_boot <= w[0];
      nv_gen  <= w[1];
      nv_osel <= w[2];
      nv_oopt <= w[3];
      nv_wdt  <= w[4];
      nv_por  <= w[5];
      nv_dbg  <= w[6];
      nv_cmp  <= w[7];
   endtask : drive

   task automatic rand_words();
      foreach (w[i]) w[i] = 8'($urandom);
      w[6][7:6] = 2'b11;
      if (w[6][1:0] == 2'b00) w[6][1:0] = 2'b11;
      watchdog_soft_enable <= 1'($urandom);
      drive();
   endtask : rand_words

   // power-up or fail-safe wait in cycles
   function automatic int pdelay();
      int pc;
      int pm;
      int ns;
      pc = w[5] & 7;
      pm = w[3] & 3;
      ns = w[2] & 7;
      if (pc != 0) return POWER_UP_DELAY_C << (pc - 1);
      // crystal counts only when the primary source is selected
      return ((ns == 2 || ns == 3) && (pm == 1 || pm == 2)) ? FSCM_C : 0;
   endfunction : pdelay

   task automatic do_reset();
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask : do_reset

   // bounded wait for execution release
   task automatic wait_exec(output int k);
      k = 0;
      while (exec_enable !== 1'b1 && k < 3000)
      begin
         @(negedge sys_clk);
         k++;
      end
      if (k >= 3000)
      begin
         $display("[FAIL] exec_enable expected 1 seen timeout");
         num_errors++;
         summarize();
      end
   endtask : wait_exec

   // ==========================================================
   // behavioural decode of the latched words
   task automatic check_decode();
      int b, g, o, q, d, p, f, c, e;
      b = w[0]; g = w[1]; o = w[2]; q = w[3]; d = w[4]; p = w[5]; f = w[6]; c = w[7];
      e = (b >> 1) & 3;
      chk("boot_present", e != 3, boot_segment_present);
      if (e != 3)
      begin
         chk("boot_end", (e == 2) ? 'h3fe : (e == 1) ? 'h7fe : 'hffe, boot_segment_end);
         chk("boot_sec", ((b >> 3) & 1) ? 1 : 2, boot_security);
      end
      e = (g >> 1) & 3;
      chk("gen_sec", (e == 3) ? 0 : (e == 2) ? 1 : 2, general_security);
      chk("gen_wp", !(g & 1), general_write_protect);
      chk("osc_sel", o & 7, initial_oscillator_select);
      chk("act_clk", o & 7, active_clock_source);
      chk("clk_sw", ((q >> 6) & 3) < 2, clock_switch_enable);
      chk("fscm", ((q >> 6) & 3) == 0, failsafe_monitor_enable);
      chk("pri_mode", q & 3, primary_osc_mode);
      e = ((q & 3) == 1 || (q & 3) == 2) ? 0 : (q >> 2) & 1;
      chk("osc_pin", e, osc_pin_clock_out);
      chk("wdt_run", ((d >> 7) & 1) ? 1'b1 : watchdog_soft_enable, watchdog_run);
      chk("wdt_win", !((d >> 6) & 1), watchdog_window_mode);
      chk("wdt_pre", ((d >> 4) & 1) ? 128 : 32, watchdog_prescale_ratio);
      chk("wdt_post", 1 << (d & 15), watchdog_postscale_ratio);
      chk("jtag", (f >> 5) & 1, jtag_enable);
      chk("dbg_pair", 1 << (3 - (f & 3)), debug_pair_onehot);
      chk("enc_pins", (p >> 6) & 1, encoder_primary_pins);
      chk("ss_alt", (p >> 5) & 1, slave_select_alternate);
      chk("hy0_pol", (c >> 2) & 1, even_hysteresis_polarity);
      chk("hy0_amt", c & 3, even_hysteresis_amount);
      chk("hy1_pol", (c >> 5) & 1, odd_hysteresis_polarity);
      chk("hy1_amt", (c >> 3) & 3, odd_hysteresis_amount);
   endtask : check_decode

   // write gating inside and outside the boot segment
   task automatic check_flash();
      @(posedge sys_clk);
      flash_wr_req  <= 1'b1;
      flash_wr_addr <= 24'h000300;
      @(negedge sys_clk);
      chk("wr_boot", (((w[0] >> 1) & 3) != 3) ? w[0][0] : w[1][0], flash_wr_allow);
      @(posedge sys_clk);
      flash_wr_addr <= 24'h008000;
      @(negedge sys_clk);
      chk("wr_gen", w[1][0], flash_wr_allow);
      @(posedge sys_clk);
      flash_wr_req <= 1'b0;
   endtask : check_flash

   // ==========================================================
   // main sequence
   initial
   begin
      {rst_n, brown_out, power_resume, tbl_rd, flash_wr_req, brown_out_flag_clr} = '0;
      {watchdog_soft_enable, tbl_addr, flash_wr_addr} = '0;
      {nv_boot, nv_gen, nv_osel, nv_oopt, nv_wdt, nv_por, nv_dbg, nv_cmp} = '0;
      osc_start_done = 1'b1;
      pll_lock       = 1'b1;
      num_errors     = 0;
      num_checks     = 0;
      void'($urandom(97));
      for (int t = 0; t < 12; t++)
      begin
         rand_words();
         do_reset();
         wait_exec(n);
         chk("startup", 1, n >= SETL_C + pdelay() && n <= SETL_C + pdelay() + 5);
         check_decode();
         foreach (ADR[i]) rd(ADR[i], w[i] & MSK[i]);
         rd(DCF_ADDR_RSVD, 8'h00);
         rd(24'hf80012, 8'h00);
         check_flash();
         sv = w;
         rand_words();
         w = sv;
         repeat (2) @(negedge sys_clk);
         check_decode();
         rd(DCF_ADDR_WDT, w[4] & DCF_MASK_WDT);
         $display("test %0d done", t);
      end
      // two-speed start on a primary oscillator with pll
      w = '{8'hff, 8'hff, 8'h83, 8'hc1, 8'h80, 8'h61, 8'he3, 8'h00};
      drive();
      osc_start_done <= 1'b0;
      pll_lock       <= 1'b0;
      do_reset();
      repeat (30) @(negedge sys_clk);
      chk("hold_exec", 0, exec_enable);
      chk("hold_clk", 1, clock_hold);
      chk("frc_first", 0, active_clock_source);
      @(posedge sys_clk);
      osc_start_done <= 1'b1;
      repeat (10) @(negedge sys_clk);
      chk("lock_wait", 0, exec_enable);
      @(posedge sys_clk);
      pll_lock <= 1'b1;
      wait_exec(n);
      check_decode();
      $display("test oscillator hold done");
      // brown-out, flag clear and power resume
      @(posedge sys_clk);
      brown_out <= 1'b1;
      @(posedge sys_clk);
      brown_out <= 1'b0;
      @(negedge sys_clk);
      chk("bo_flag", 1, brown_out_flag);
      chk("bo_exec", 0, exec_enable);
      chk("bo_reset", 1, core_reset);
      wait_exec(n);
      chk("bo_delay", 1, n + 1 >= SETL_C + pdelay());
      chk("bo_kept", 1, brown_out_flag);
      @(posedge sys_clk);
      brown_out_flag_clr <= 1'b1;
      @(posedge sys_clk);
      brown_out_flag_clr <= 1'b0;
      @(negedge sys_clk);
      chk("bo_clr", 0, brown_out_flag);
      @(posedge sys_clk);
      power_resume <= 1'b1;
      @(posedge sys_clk);
      power_resume <= 1'b0;
      @(negedge sys_clk);
      chk("pr_exec", 0, exec_enable);
      wait_exec(n);
      chk("pr_settle", 1, n + 1 >= SETL_C);
      chk("pr_flag", 0, brown_out_flag);
      $display("test brown-out done");
      summarize();
   end
endmodule : dcf_config_loader_tb
